// ===== hdl/iox_expander.v
// Two-wire slave 16-bit quasi-bidirectional I/O expander
//
// Functional notes
// - Addressed slave; receives in write direction, transmits in read direction.
// - Three address select inputs form the low slave address bits.
// - Oversampling at mclk keeps pace with 400 kbit/s bus traffic.
// - First byte after start holds seven-bit address and direction bit.
// - Data bytes pair low port first, then high port, repeating.
// - Sixteen independent pins, input or output, no direction bits.
// - Read sends pin levels; write makes received bytes the new outputs.
// - After reset every pin is released, usable as input.
// - Pin written high gets strong pull-up until next SCL falling edge.
// - Latch holds last written value; low pins keep driving low.
// - Active-low open-drain interrupt flags changed inputs without bus traffic.
// - Direction bit one selects read, zero selects write.
// - Write acks each byte; pins update after acked second byte of pair.
// - Input edge raises interrupt; clears on return, read or write.
`timescale 1ns/10ps
`default_nettype none
`include "iox_regs.vh"
module iox_expander #(
   parameter [3:0] ADDR_HI = `IOX_ADDR_HI_DFLT
) (
   // Clock and reset
   input  wire        mclk,
   input  wire        rst_b,
   // Address selects
   input  wire        slave_addr_sel0,
   input  wire        slave_addr_sel1,
   input  wire        slave_addr_sel2,
   // Two-wire bus
   input  wire        scl_in,
   input  wire        sda_in,
   output wire        sda_o,
   output wire        sda_oe,
   // Port pins, high port in 15:8
   input  wire [15:0] port_in,
   output wire [15:0] port_o,
   output wire [15:0] port_oe,
   // Interrupt, open drain
   output wire        int_o,
   output wire        int_oe
);
   localparam ST_IDLE = 3'h0;
   localparam ST_ADDR = 3'h1;
   localparam ST_AACK = 3'h2;
   localparam ST_WRX  = 3'h3;
   localparam ST_WACK = 3'h4;
   localparam ST_RTX  = 3'h5;
   localparam ST_RACK = 3'h6;
   localparam ST_IGN  = 3'h7;

   // Open-drain: drive low while the bit to send is zero
   function oe_for_bit;
      input b;
      begin
         oe_for_bit = ~b;
      end
   endfunction

   //==========================================================
   // Input synchronisers
   //==========================================================
   reg [2:0]  scl_s_ff;
   reg [2:0]  sda_s_ff;
   reg [15:0] pin_s1_ff;
   reg [15:0] pin_s2_ff;
   reg [2:0]  asel_s1_ff;
   reg [2:0]  asel_s2_ff;

   always @(posedge mclk) begin
      if (!rst_b) begin
         scl_s_ff   <= 3'h7;
         sda_s_ff   <= 3'h7;
         pin_s1_ff  <= 16'hFFFF;
         pin_s2_ff  <= 16'hFFFF;
         asel_s1_ff <= 3'h0;
         asel_s2_ff <= 3'h0;
      end else begin
         scl_s_ff   <= {scl_s_ff[1:0], scl_in};
         sda_s_ff   <= {sda_s_ff[1:0], sda_in};
         pin_s1_ff  <= port_in;
         pin_s2_ff  <= pin_s1_ff;
         asel_s1_ff <= {slave_addr_sel2, slave_addr_sel1, slave_addr_sel0};
         asel_s2_ff <= asel_s1_ff;
      end
   end

   wire scl      = scl_s_ff[1];
   wire sda      = sda_s_ff[1];
   wire scl_rise = scl_s_ff[1] & ~scl_s_ff[2];
   wire scl_fall = ~scl_s_ff[1] & scl_s_ff[2];
   wire bus_start = scl & scl_s_ff[2] & ~sda_s_ff[1] & sda_s_ff[2];
   wire bus_stop  = scl & scl_s_ff[2] & sda_s_ff[1] & ~sda_s_ff[2];

   //==========================================================
   // Bus slave state machine
   //==========================================================
   reg [2:0]  state_ff;
   reg [3:0]  bitcnt_ff;
   reg [7:0]  shreg_ff;
   reg [7:0]  txbyte_ff;
   reg [7:0]  tx_hi_ff;
   reg        tx_phase_ff;
   reg        mack_ff;
   reg        sda_oe_ff;
   reg        push_ff;
   reg        rd_sample_ff;
   wire       fifo_in_ready;

   wire addr_hit = (shreg_ff[7:1] == {ADDR_HI, asel_s2_ff});

   always @(posedge mclk) begin
      if (!rst_b) begin
         state_ff     <= ST_IDLE;
         bitcnt_ff    <= 4'h0;
         shreg_ff     <= 8'h00;
         txbyte_ff    <= 8'h00;
         tx_hi_ff     <= 8'h00;
         tx_phase_ff  <= 1'b0;
         mack_ff      <= 1'b0;
         sda_oe_ff    <= 1'b0;
         push_ff      <= 1'b0;
         rd_sample_ff <= 1'b0;
      end else begin
         push_ff      <= 1'b0;
         rd_sample_ff <= 1'b0;
         if (bus_start) begin
            state_ff  <= ST_ADDR;
            bitcnt_ff <= 4'h0;
            sda_oe_ff <= 1'b0;
         end else if (bus_stop) begin
            state_ff  <= ST_IDLE;
            sda_oe_ff <= 1'b0;
         end else if (scl_rise) begin
            if (state_ff == ST_ADDR || state_ff == ST_WRX) begin
               shreg_ff  <= {shreg_ff[6:0], sda};
               bitcnt_ff <= bitcnt_ff + 4'h1;
            end
            if (state_ff == ST_RACK) begin
               mack_ff <= ~sda;
            end
         end else if (scl_fall) begin
            case (state_ff)
               ST_ADDR: begin
                  if (bitcnt_ff == `IOX_BYTE_BITS) begin
                     if (addr_hit) begin
                        state_ff  <= ST_AACK;
                        sda_oe_ff <= 1'b1;
                     end else begin
                        state_ff <= ST_IGN;
                     end
                  end
               end
               ST_AACK: begin
                  bitcnt_ff   <= 4'h0;
                  tx_phase_ff <= 1'b0;
                  if (shreg_ff[`IOX_RW_BIT]) begin
                     state_ff     <= ST_RTX;
                     txbyte_ff    <= pin_s2_ff[7:0];
                     tx_hi_ff     <= pin_s2_ff[15:8];
                     rd_sample_ff <= 1'b1;
                     sda_oe_ff    <= oe_for_bit(pin_s2_ff[7]);
                  end else begin
                     state_ff  <= ST_WRX;
                     sda_oe_ff <= 1'b0;
                  end
               end
               ST_WRX: begin
                  if (bitcnt_ff == `IOX_BYTE_BITS) begin
                     if (fifo_in_ready) begin
                        state_ff  <= ST_WACK;
                        sda_oe_ff <= 1'b1;
                     end else begin
                        state_ff <= ST_IGN;
                     end
                  end
               end
               ST_WACK: begin
                  state_ff  <= ST_WRX;
                  bitcnt_ff <= 4'h0;
                  sda_oe_ff <= 1'b0;
                  push_ff   <= 1'b1;
               end
               ST_RTX: begin
                  if (bitcnt_ff == 4'h7) begin
                     state_ff  <= ST_RACK;
                     sda_oe_ff <= 1'b0;
                  end else begin
                     bitcnt_ff <= bitcnt_ff + 4'h1;
                     txbyte_ff <= {txbyte_ff[6:0], 1'b0};
                     sda_oe_ff <= oe_for_bit(txbyte_ff[6]);
                  end
               end
               ST_RACK: begin
                  bitcnt_ff <= 4'h0;
                  if (!mack_ff) begin
                     state_ff <= ST_IGN;
                  end else if (!tx_phase_ff) begin
                     state_ff    <= ST_RTX;
                     tx_phase_ff <= 1'b1;
                     txbyte_ff   <= tx_hi_ff;
                     sda_oe_ff   <= oe_for_bit(tx_hi_ff[7]);
                  end else begin
                     state_ff     <= ST_RTX;
                     tx_phase_ff  <= 1'b0;
                     txbyte_ff    <= pin_s2_ff[7:0];
                     tx_hi_ff     <= pin_s2_ff[15:8];
                     rd_sample_ff <= 1'b1;
                     sda_oe_ff    <= oe_for_bit(pin_s2_ff[7]);
                  end
               end
               default: begin
                  sda_oe_ff <= 1'b0;
               end
            endcase
         end
      end
   end

   //==========================================================
   // Write byte buffer and pairing
   //==========================================================
   wire       fifo_out_valid;
   wire [7:0] fifo_out_data;
   reg        drain_phase_ff;
   reg  [7:0] low_hold_ff;
   reg        upd_ff;
   wire       fifo_out_ready = ~upd_ff;

   iox_fifo #(
      .W  (8),
      .D  (`IOX_FIFO_DEPTH),
      .AW (`IOX_FIFO_AW)
   ) u_fifo (
      .mclk      (mclk),
      .rst_b     (rst_b),
      .in_valid  (push_ff),
      .in_ready  (fifo_in_ready),
      .in_data   (shreg_ff),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   reg [15:0] latch_ff;
   reg [15:0] pullup_ff;

   always @(posedge mclk) begin
      if (!rst_b) begin
         drain_phase_ff <= 1'b0;
         low_hold_ff    <= 8'h00;
         upd_ff         <= 1'b0;
         latch_ff       <= `IOX_LATCH_RST;
         pullup_ff      <= 16'h0000;
      end else begin
         upd_ff <= 1'b0;
         if (scl_fall) begin
            pullup_ff <= 16'h0000;
         end
         if (bus_start && !fifo_out_valid) begin
            drain_phase_ff <= 1'b0;
         end else if (fifo_out_valid && fifo_out_ready) begin
            if (!drain_phase_ff) begin
               low_hold_ff    <= fifo_out_data;
               drain_phase_ff <= 1'b1;
            end else begin
               latch_ff       <= {fifo_out_data, low_hold_ff};
               pullup_ff      <= {fifo_out_data, low_hold_ff};
               drain_phase_ff <= 1'b0;
               upd_ff         <= 1'b1;
            end
         end
      end
   end

   //==========================================================
   // Pin drive and interrupt
   //==========================================================
   reg [15:0] port_o_ff;
   reg [15:0] port_oe_ff;
   reg [15:0] ref_ff;
   reg [1:0]  ref_init_ff;
   reg        int_oe_ff;

   always @(posedge mclk) begin
      if (!rst_b) begin
         port_o_ff   <= 16'h0000;
         port_oe_ff  <= 16'h0000;
         ref_ff      <= 16'hFFFF;
         ref_init_ff <= 2'h0;
         int_oe_ff   <= 1'b0;
      end else begin
         port_o_ff  <= pullup_ff;
         port_oe_ff <= ~latch_ff | pullup_ff;
         // Reference tracks pins until synchronisers and pin drive settle
         if (ref_init_ff != 2'h3 || rd_sample_ff || upd_ff) begin
            ref_ff    <= pin_s2_ff;
            int_oe_ff <= 1'b0;
         end else begin
            int_oe_ff <= (pin_s2_ff != ref_ff);
         end
         if (rd_sample_ff || upd_ff) begin
            ref_init_ff <= 2'h0;
         end else if (ref_init_ff != 2'h3) begin
            ref_init_ff <= ref_init_ff + 2'h1;
         end
      end
   end

   assign sda_o   = 1'b0;
   assign sda_oe  = sda_oe_ff;
   assign port_o  = port_o_ff;
   assign port_oe = port_oe_ff;
   assign int_o   = 1'b0;
   assign int_oe  = int_oe_ff;
endmodule // iox_expander
`default_nettype wire

// ===== hdl/iox_regs.vh
// Constants of the 16-bit two-wire I/O expander
`ifndef IOX_REGS_VH
`define IOX_REGS_VH

// Clock rate and fastest supported bus rate
`define IOX_MCLK_KHZ      50000
`define IOX_BUS_MAX_KBPS  400
`define IOX_BIT_CYC       (`IOX_MCLK_KHZ / `IOX_BUS_MAX_KBPS)

// Address byte layout
`define IOX_ADDR_HI_DFLT  4'h4
`define IOX_RW_BIT        0
`define IOX_BYTE_BITS     4'h8

// Reset values and write buffer size
`define IOX_LATCH_RST     16'hFFFF
`define IOX_FIFO_DEPTH    8
`define IOX_FIFO_AW       3

`endif

// ===== hdl/iox_fifo.v
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module iox_fifo #(
   parameter W  = 8,
   parameter D  = 8,
   parameter AW = 3
) (
   // Clock and reset
   input  wire          mclk,
   input  wire          rst_b,
   // Fill side
   input  wire          in_valid,
   output wire          in_ready,
   input  wire [W-1:0]  in_data,
   // Drain side
   output wire          out_valid,
   input  wire          out_ready,
   output wire [W-1:0]  out_data
);
   reg [W-1:0]  mem [0:D-1];
   reg [AW-1:0] wr_ptr_ff;
   reg [AW-1:0] rd_ptr_ff;
   reg [AW:0]   count_ff;
   wire         push;
   wire         pop;

   assign in_ready  = (count_ff != D[AW:0]);
   assign out_valid = (count_ff != {(AW+1){1'b0}});
   assign out_data  = mem[rd_ptr_ff];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge mclk) begin
      if (push) begin
         mem[wr_ptr_ff] <= in_data;
      end
   end

   always @(posedge mclk) begin
      if (!rst_b) begin
         wr_ptr_ff <= {AW{1'b0}};
         rd_ptr_ff <= {AW{1'b0}};
         count_ff  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_ff <= wr_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_ptr_ff <= rd_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
         end
         if (push && !pop) begin
            count_ff <= count_ff + {{AW{1'b0}}, 1'b1};
         end else if (pop && !push) begin
            count_ff <= count_ff - {{AW{1'b0}}, 1'b1};
         end
      end
   end
endmodule // iox_fifo
`default_nettype wire

// ===== bench/iox_expander_assertions.sv
// Checker of the expander's bus, port and interrupt outputs
`timescale 1ns/10ps
`default_nettype none
module iox_expander_chk (
   // Clock and reset
   input wire logic        mclk,
   input wire logic        rst_b,
   // Bus
   input wire logic        scl_in,
   input wire logic        sda_o,
   input wire logic        sda_oe,
   // Pins and interrupt
   input wire logic [15:0] port_in,
   input wire logic [15:0] port_o,
   input wire logic [15:0] port_oe,
   input wire logic        int_o,
   input wire logic        int_oe
);
   logic [3:0] fall_age_ff;
   logic       scl_ff;
   // Cycles since the last bus clock fall, saturating
   always_ff @(posedge mclk) begin
      scl_ff <= scl_in;
      if (!rst_b) fall_age_ff <= 4'hF;
      else if (scl_ff && !scl_in) fall_age_ff <= 4'h0;
      else if (fall_age_ff != 4'hF) fall_age_ff <= fall_age_ff + 4'h1;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   sequence scl_fall_s;
      $fell(scl_in);
   endsequence
   sequence pullup_off_s;
      ##[1:10] (port_o == 16'h0);
   endsequence
   sda_od_a: assert property (sda_o == 1'b0)
      else $error("data line driven high");
   int_od_a: assert property (int_o == 1'b0)
      else $error("interrupt line driven high");
   reset_idle_a: assert property ($rose(rst_b) |->
      port_oe == 16'h0 && !sda_oe && !int_oe)
      else $error("outputs active after reset");
   pullup_oe_a: assert property ((port_o & ~port_oe) == 16'h0)
      else $error("pull-up level without drive");
   pullup_drop_a: assert property (scl_fall_s ##0 (port_o != 16'h0) |-> pullup_off_s)
      else $error("pull-up kept past clock fall");
   low_drive_a: assert property ($changed(port_oe & ~port_o) |-> fall_age_ff <= 4'hC)
      else $error("pin drive changed away from a bus clock fall");
   sda_move_a: assert property ($changed(sda_oe) |-> fall_age_ff <= 4'h5)
      else $error("data line moved outside clock low");
   int_rise_a: assert property ($rose(int_oe) |-> port_in != $past(port_in, 6))
      else $error("interrupt without pin change");
   int_fall_a: assert property ($fell(int_oe) |->
      fall_age_ff <= 4'hC || port_in != $past(port_in, 6))
      else $error("interrupt cleared without cause");
endmodule // iox_expander_chk
`default_nettype wire

// ===== bench/iox_bus_master.sv
// Two-wire bus master model driving the expander
`timescale 1ns/10ps
`default_nettype none
module iox_bus_master (
   // Clock
   input  wire logic mclk,
   // Bus wires
   input  wire logic sda_w,
   output var  logic scl,
   output var  logic sda_low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // Data set in clock low, read at end of clock high
   task automatic bit_io(input logic b, output logic r);
      hold(1);
      sda_low <= ~b;
      hold(3);
      scl <= 1'b1;
      hold(4);
      r = sda_w;
      scl <= 1'b0;
   endtask
   task automatic start;
      hold(1);
      sda_low <= 1'b0;
      hold(3);
      scl <= 1'b1;
      hold(4);
      sda_low <= 1'b1;
      hold(4);
      scl <= 1'b0;
   endtask
   task automatic stop;
      hold(1);
      sda_low <= 1'b1;
      hold(3);
      scl <= 1'b1;
      hold(4);
      sda_low <= 1'b0;
      hold(4);
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   task automatic rbyte(output logic [7:0] d, input logic mack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(~mack, r);
   endtask
endmodule // iox_bus_master
`default_nettype wire

// ===== bench/iox_expander_tb.sv
// Self-checking testbench of the two-wire I/O expander
`timescale 1ns/10ps
`default_nettype none
`include "iox_regs.vh"
module iox_expander_tb;
   logic        mclk, rst_b, scl, sda_low, sda_o, sda_oe, sda_w, int_o, int_oe, ack;
   logic [2:0]  sel;
   logic [15:0] ext, port_o, port_oe, pins, v;
   integer      seed = 59, error_cnt = 0, checks = 0;
   assign sda_w = ~sda_low & ~sda_oe;
   assign pins  = (port_oe & port_o) | (~port_oe & ext);
   iox_bus_master m (.mclk(mclk), .sda_w(sda_w), .scl(scl), .sda_low(sda_low));
   iox_expander DUT (.mclk(mclk), .rst_b(rst_b), .slave_addr_sel0(sel[0]),
      .slave_addr_sel1(sel[1]), .slave_addr_sel2(sel[2]), .scl_in(scl), .sda_in(sda_w),
      .sda_o(sda_o), .sda_oe(sda_oe), .port_in(pins), .port_o(port_o), .port_oe(port_oe),
      .int_o(int_o), .int_oe(int_oe));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   function automatic logic [7:0] addr_byte(input logic rw);
      return {`IOX_ADDR_HI_DFLT, sel, rw};
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks = checks + 1;
      if (seen !== exp) begin
         error_cnt = error_cnt + 1;
         $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      $display("checks %0d, mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic do_reset;
      rst_b <= 1'b0;
      repeat (4) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (4) @(posedge mclk);
      check(port_oe, 16'h0);
      check(16'({sda_oe, int_oe}), 16'h0);
   endtask
   // Random pair, then d, then an optional lone byte
   task automatic wr(input logic [15:0] d, input logic odd);
      logic [15:0] pre;
      logic [7:0]  q[$];
      pre = 16'($random(seed));
      q = {pre[7:0], pre[15:8], d[7:0], d[15:8]};
      if (odd) q.push_back(8'h5A);
      m.start;
      m.wbyte(addr_byte(1'b0), ack);
      check(16'(ack), 16'h1);
      foreach (q[i]) begin
         m.wbyte(q[i], ack);
         check(16'(ack), 16'h1);
      end
      m.stop;
      repeat (10) @(posedge mclk);
      check(port_oe & ~port_o, ~d);
      check(port_o, odd ? 16'h0 : d);
   endtask
   // Read np pairs, pins move after each low byte except the last pair's
   task automatic rd(input int np);
      logic [7:0]  lo, hi;
      logic [15:0] e, nx;
      e = ext;
      m.start;
      m.wbyte(addr_byte(1'b1), ack);
      check(16'(ack), 16'h1);
      for (int i = 0; i < np; i++) begin
         m.rbyte(lo, 1'b1);
         nx = (i < np - 1) ? 16'($random(seed)) : e;
         ext <= nx;
         m.rbyte(hi, i < np - 1);
         check({hi, lo}, e);
         e = nx;
      end
      m.stop;
   endtask
   task automatic wait_int(input logic lvl);
      for (int i = 0; i < 20 && int_oe !== lvl; i++) @(posedge mclk);
      check(16'(int_oe), 16'(lvl));
      if (int_oe !== lvl) summarize;
   endtask
   initial begin
      rst_b = 1'b0;
      sel = 3'h0;
      ext = 16'hFFFF;
      @(posedge mclk);
      do_reset;
      $display("test reset done");
      m.start;
      m.wbyte(addr_byte(1'b0) ^ 8'h02, ack);
      m.stop;
      check(16'(ack), 16'h0);
      $display("test wrong address done");
      for (int n = 0; n < 6; n++) begin
         sel <= 3'($random(seed));
         ext <= 16'($random(seed));
         v = (n == 0) ? 16'h0000 : (n == 1) ? 16'hFFFF : 16'($random(seed));
         repeat (4) @(posedge mclk);
         wr(v, n == 3);
      end
      $display("test writes done");
      do_reset;
      $display("test second reset done");
      wr(16'hFFFF, 1'b0);
      ext <= 16'($random(seed));
      @(posedge mclk);
      rd(3);
      check(port_o | port_oe, 16'h0);
      wait_int(1'b0);
      $display("test read done");
      ext <= ext ^ 16'h8001;
      wait_int(1'b1);
      ext <= ext ^ 16'h8001;
      wait_int(1'b0);
      ext <= ext ^ 16'h0010;
      wait_int(1'b1);
      rd(1);
      wait_int(1'b0);
      ext <= ext ^ 16'h0100;
      wait_int(1'b1);
      wr(16'hFFFF, 1'b0);
      wait_int(1'b0);
      $display("test interrupt done");
      summarize;
   end
endmodule // iox_expander_tb
bind iox_expander iox_expander_chk chk (.mclk(mclk), .rst_b(rst_b), .scl_in(scl_in),
   .sda_o(sda_o), .sda_oe(sda_oe), .port_in(port_in), .port_o(port_o), .port_oe(port_oe),
   .int_o(int_o), .int_oe(int_oe));
`default_nettype wire
